// ===== inc/scm_pkg.sv
// constants and types for the system clock and mode select block
package scm_pkg;
	localparam int            DIV_FIXED       = 5;
	localparam int            SET_W           = 9;
	localparam int            ND_W            = 5;
	localparam int            WR_W            = 4;
	localparam int            QTR_W           = 2;
	localparam logic [8:0]    SET_RESET       = 9'h10b;
	localparam logic [8:0]    STRAP_INV_MASK  = 9'h174;
	localparam logic [3:0]    WR_FIELD_RESET  = 4'h9;
	localparam logic [2:0]    MODE_EXT_SCAN   = 3'h3;
	localparam logic [2:0]    MODE_PLL_SCAN   = 3'h4;
	localparam logic [2:0]    MODE_PLL_DEBUG  = 3'h6;
	localparam logic [2:0]    MODE_EXT_DEBUG  = 3'h7;
	localparam int            ND_LSB          = 0;
	localparam int            FS_LSB          = 5;
	localparam int            IS_LSB          = 7;

	typedef enum logic [2:0]
	{
		SCM_EXT_SCAN,
		SCM_PLL_SCAN,
		SCM_PLL_DEBUG,
		SCM_EXT_DEBUG,
		SCM_RESERVED
	} scm_mode_t;
endpackage

// ===== inc/scm_div_if.sv
// carrier between the top and the fixed divider
`timescale 1ns/1ps
`default_nettype none
interface scm_div_if;
	logic run;
	logic tick;

	modport ctrl
	(
		output run,
		input  tick
	);
	modport div
	(
		input  run,
		output tick
	);
endinterface
`default_nettype wire

// ===== rtl/scm_fixed_div.sv
// divide-by-n enable generator for the fixed divided clock
`timescale 1ns/1ps
`default_nettype none
module scm_fixed_div
#(
	parameter int DIV = scm_pkg::DIV_FIXED
)
(
	// clock and reset
	input  wire logic system_clock_i,
	input  wire logic sys_rst_i,
	// control
	scm_div_if.div    dif
);
	localparam int CW = $clog2(DIV);

	initial
	begin
		if (DIV < 2)
			$error("scm_fixed_div: DIV must be at least 2");
	end

	logic [CW-1:0] cnt_q;
	logic          tick_q;

	always_ff @(posedge system_clock_i)
	begin
		if (sys_rst_i || !dif.run)
		begin
			cnt_q  <= '0;
			tick_q <= 1'b0;
		end
		else if (cnt_q == CW'(DIV - 1))
		begin
			cnt_q  <= '0;
			tick_q <= 1'b1;
		end
		else
		begin
			cnt_q  <= cnt_q + 1'b1;
			tick_q <= 1'b0;
		end
	end

	assign dif.tick = tick_q;
endmodule
`default_nettype wire

// ===== rtl/scm_top.sv
// clock generation and chip mode select
// Behaviour
// - decode straps: 011, 100, 110 modes
// - strap 111: oscillator, debugger tap
// - oscillator mode: bus clock equals input
// - oscillator mode: fixed clock is input/5
// - pll mode: bus clock in quarter steps
// - pll mode: fixed clock always crystal/5
// - bus clock pin only when disable 0
// - fixed clock for refresh, selectable timers
// - sample nine low address lines at boot
// - invert address bits 8,6,5,4,2 on capture
// - low chip reset forces full reset
// - boundary scan modes give jtag pin control
// - after boot, settings only changed via multiplier write
// - settings loaded from straps at boot
`timescale 1ns/1ps
`default_nettype none
module scm_top
#(
	parameter int ND_W = scm_pkg::ND_W
)
(
	// clock and reset
	input  wire logic                     system_clock_i,
	input  wire logic                     sys_rst_i,
	input  wire logic                     system_reset_n_i,
	// mode straps
	input  wire logic                     pll_test_strap_i,
	input  wire logic                     selftest_strap_i,
	input  wire logic                     scan_strap_i,
	// boot straps on the address lines
	input  wire logic [scm_pkg::SET_W-1:0] addr_strap_i,
	// control
	input  wire logic                     bus_clock_pin_disable_i,
	input  wire logic                     timer_fixed_sel_i,
	input  wire logic                     pll_ctrl_wr_i,
	input  wire logic [scm_pkg::WR_W-1:0] pll_multiplier_write_field_i,
	// clock enables
	output logic                          bus_clk_en_o,
	output logic [scm_pkg::QTR_W+ND_W-1:0] bus_ticks_o,
	output logic                          bus_clk_pin_o,
	output logic                          bus_clk_pin_oe_o,
	output logic                          fixed_divided_clock_o,
	output logic                          refresh_tick_o,
	output logic                          timer_tick_o,
	// mode and status
	output logic                          use_pll_o,
	output logic                          debug_tap_sel_o,
	output logic                          boundary_scan_en_o,
	output logic                          mode_reserved_o,
	output logic [scm_pkg::SET_W-1:0]     pll_settings_o,
	output logic [scm_pkg::WR_W-1:0]      pll_multiplier_write_field_o
);
	localparam int TW = scm_pkg::QTR_W + ND_W;
	// largest tick count: full multiplier plus the biggest remainder
	localparam int TICK_MAX = ((1 << scm_pkg::QTR_W) - 1 + (1 << ND_W)) >> scm_pkg::QTR_W;

	initial
	begin
		if (ND_W != scm_pkg::ND_W)
			$error("scm_top: ND_W must match the settings layout");
		if (scm_pkg::FS_LSB != scm_pkg::ND_LSB + ND_W)
			$error("scm_top: divider field must sit right above the multiplier");
		if (scm_pkg::IS_LSB != scm_pkg::FS_LSB + 2)
			$error("scm_top: pump field must sit right above the divider field");
		if (scm_pkg::SET_W != scm_pkg::IS_LSB + 2)
			$error("scm_top: settings width does not match its fields");
		if (scm_pkg::WR_W > ND_W)
			$error("scm_top: write field wider than the multiplier");
		if (scm_pkg::QTR_W != 2)
			$error("scm_top: bus clock steps are quarters of the crystal");
		if (TICK_MAX >= (1 << TW))
			$error("scm_top: tick count does not fit");
		if (scm_pkg::DIV_FIXED < 2)
			$error("scm_top: fixed divider must divide by at least 2");
	end

	logic                      rst;
	logic                      booted_q;
	logic                      wr_take;
	logic [scm_pkg::SET_W-1:0] strap_cap;
	logic [scm_pkg::SET_W-1:0] set_q;
	logic [ND_W-1:0]           nd_cur;
	logic [scm_pkg::WR_W-1:0]  wr_field_q;
	logic [scm_pkg::QTR_W-1:0] frac_q;
	logic [scm_pkg::QTR_W-1:0] frac_d;
	logic [TW-1:0]             acc;
	logic [TW-1:0]             bus_ticks_d;
	scm_pkg::scm_mode_t        mode_d;
	logic                      pll_mode;
	scm_div_if                 dif();

	assign rst = sys_rst_i || !system_reset_n_i;

	// writes are refused until the boot capture has happened
	assign wr_take = booted_q && pll_ctrl_wr_i;

	// boot straps with the inverted positions flipped
	for (genvar i = 0; i < scm_pkg::SET_W; i++)
	begin : g_strap
		assign strap_cap[i] = scm_pkg::STRAP_INV_MASK[i] ? !addr_strap_i[i] : addr_strap_i[i];
	end

	always_comb
	begin
		case ({pll_test_strap_i, selftest_strap_i, scan_strap_i})
			scm_pkg::MODE_EXT_SCAN:  mode_d = scm_pkg::SCM_EXT_SCAN;
			scm_pkg::MODE_PLL_SCAN:  mode_d = scm_pkg::SCM_PLL_SCAN;
			scm_pkg::MODE_PLL_DEBUG: mode_d = scm_pkg::SCM_PLL_DEBUG;
			scm_pkg::MODE_EXT_DEBUG: mode_d = scm_pkg::SCM_EXT_DEBUG;
			default:                 mode_d = scm_pkg::SCM_RESERVED;
		endcase
	end

	// what each strap mode turns on
	always_comb
	begin
		pll_mode           = 1'b0;
		debug_tap_sel_o    = 1'b0;
		boundary_scan_en_o = 1'b0;
		mode_reserved_o    = 1'b0;
		case (mode_d)
			scm_pkg::SCM_EXT_SCAN:
				boundary_scan_en_o = 1'b1;
			scm_pkg::SCM_PLL_SCAN:
			begin
				pll_mode           = 1'b1;
				boundary_scan_en_o = 1'b1;
			end
			scm_pkg::SCM_PLL_DEBUG:
			begin
				pll_mode        = 1'b1;
				debug_tap_sel_o = 1'b1;
			end
			scm_pkg::SCM_EXT_DEBUG:
				debug_tap_sel_o = 1'b1;
			default:
				mode_reserved_o = 1'b1;
		endcase
	end

	assign use_pll_o = pll_mode;

	// boot capture of the address straps, one cycle after release
	always_ff @(posedge system_clock_i)
	begin
		if (rst)
			booted_q <= 1'b0;
		else
			booted_q <= 1'b1;
	end

	always_ff @(posedge system_clock_i)
	begin
		if (rst)
			set_q <= scm_pkg::SET_RESET;
		else if (!booted_q)
			set_q <= strap_cap;
		else if (wr_take)
			set_q[scm_pkg::ND_LSB +: ND_W] <= ND_W'(pll_multiplier_write_field_i);
	end

	always_ff @(posedge system_clock_i)
	begin
		if (rst)
			wr_field_q <= scm_pkg::WR_FIELD_RESET;
		else if (wr_take)
			wr_field_q <= pll_multiplier_write_field_i;
	end

	assign pll_settings_o               = set_q;
	assign pll_multiplier_write_field_o = wr_field_q;

	// quarter-step rate: ticks per crystal cycle = (frac + nd + 1) / 4
	assign nd_cur = set_q[scm_pkg::ND_LSB +: ND_W];
	assign acc    = TW'(frac_q) + TW'(nd_cur) + TW'(1);

	// next tick count and quarter remainder
	always_comb
	begin
		frac_d      = '0;
		bus_ticks_d = TW'(1);
		if (pll_mode)
		begin
			frac_d      = acc[scm_pkg::QTR_W-1:0];
			bus_ticks_d = acc >> scm_pkg::QTR_W;
		end
	end

	always_ff @(posedge system_clock_i)
	begin
		if (rst || !pll_mode)
			frac_q <= '0;
		else
			frac_q <= frac_d;
	end

	always_ff @(posedge system_clock_i)
	begin
		if (rst)
			bus_ticks_o <= '0;
		else
			bus_ticks_o <= bus_ticks_d;
	end

	assign bus_clk_en_o     = (bus_ticks_o != '0);
	assign bus_clk_pin_oe_o = !bus_clock_pin_disable_i;
	assign bus_clk_pin_o    = bus_clk_en_o && !bus_clock_pin_disable_i;

	// fixed divided clock runs from the crystal in every mode
	assign dif.run = booted_q;

	scm_fixed_div #(.DIV(scm_pkg::DIV_FIXED)) u_div
	(
		.system_clock_i (system_clock_i),
		.sys_rst_i (rst),
		.dif       (dif.div)
	);

	assign fixed_divided_clock_o = dif.tick;
	assign refresh_tick_o        = dif.tick;
	assign timer_tick_o          = timer_fixed_sel_i ? dif.tick : bus_clk_en_o;
endmodule
`default_nettype wire

// ===== test/scm_strap_model.sv
// board strap resistors and pulldowns feeding the mode and address straps
`timescale 1ns/1ps
`default_nettype none
module scm_strap_model
(
	// board choices
	input  wire logic [2:0] mode_i,
	input  wire logic [8:0] pins_i,
	// strap levels
	output logic            pll_test_o,
	output logic            selftest_o,
	output logic            scan_o,
	output logic [8:0]      addr_o
);
	assign {pll_test_o, selftest_o, scan_o} = mode_i;
	assign addr_o = pins_i;
endmodule
`default_nettype wire

// ===== test/scm_top_props.sv
// assertion checker for the clock and mode select top
`timescale 1ns/1ps
`default_nettype none
module scm_top_props
#(
	parameter int ND_W = scm_pkg::ND_W
)
(
	input wire logic system_clock_i, sys_rst_i, system_reset_n_i,
	input wire logic pll_test_strap_i, selftest_strap_i, scan_strap_i,
	input wire logic [scm_pkg::SET_W-1:0] addr_strap_i,
	input wire logic bus_clock_pin_disable_i, timer_fixed_sel_i, pll_ctrl_wr_i,
	input wire logic [scm_pkg::WR_W-1:0] pll_multiplier_write_field_i,
	input wire logic bus_clk_en_o, bus_clk_pin_o, bus_clk_pin_oe_o,
	input wire logic [scm_pkg::QTR_W+ND_W-1:0] bus_ticks_o,
	input wire logic fixed_divided_clock_o, refresh_tick_o, timer_tick_o,
	input wire logic use_pll_o, debug_tap_sel_o, boundary_scan_en_o, mode_reserved_o,
	input wire logic [scm_pkg::SET_W-1:0] pll_settings_o
);
	wire logic [2:0] s = {pll_test_strap_i, selftest_strap_i, scan_strap_i};
	wire logic       rst = sys_rst_i | ~system_reset_n_i;
	wire logic [3:0] hi = pll_settings_o[8:5];
	wire logic       fx = fixed_divided_clock_o;
	default clocking @(posedge system_clock_i); endclocking
	pll_select_a: assert property (use_pll_o == (s == 3'h4 || s == 3'h6)) else $error("pll select wrong");
	debug_tap_a: assert property (debug_tap_sel_o == (s == 3'h6 || s == 3'h7)) else $error("tap select wrong");
	scan_enable_a: assert property (boundary_scan_en_o == (s == 3'h3 || s == 3'h4)) else $error("scan wrong");
	pin_gate_a: assert property ({bus_clk_pin_oe_o, bus_clk_pin_o} ==
		{!bus_clock_pin_disable_i, bus_clk_en_o & !bus_clock_pin_disable_i}) else $error("pin gate wrong");
	fixed_period_a: assert property (disable iff (rst) fx |=> !fx [*4] ##1 fx) else $error("fixed period");
	tick_route_a: assert property (refresh_tick_o == fx && timer_tick_o ==
		(timer_fixed_sel_i ? fx : bus_clk_en_o)) else $error("tick route wrong");
	osc_rate_a: assert property (disable iff (rst) !use_pll_o && $stable(use_pll_o) && !$past(rst)
		|-> bus_ticks_o == 1) else $error("osc rate wrong");
	boot_capture_a: assert property ($past(rst) && !rst |=>
		pll_settings_o == ($past(addr_strap_i) ^ scm_pkg::STRAP_INV_MASK)) else $error("boot capture");
	reset_value_a: assert property (rst |=> pll_settings_o == scm_pkg::SET_RESET && bus_ticks_o == 0 && !fx)
		else $error("reset value");
	write_nd_a: assert property (disable iff (rst) pll_ctrl_wr_i && !$past(rst) |=> pll_settings_o ==
		{$past(hi), 1'b0, $past(pll_multiplier_write_field_i)}) else $error("write wrong");
	settings_hold_a: assert property (disable iff (rst) !pll_ctrl_wr_i && !$past(rst) |=>
		$stable(pll_settings_o)) else $error("settings moved");
endmodule
bind scm_top scm_top_props #(.ND_W(ND_W)) u_props (.*);
`default_nettype wire

// ===== test/testbench.sv
// self-checking testbench for the clock and mode select top
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic system_clock_i = 1'b0, sys_rst_i = 1'b1, rst_n = 1'b1, dis = 1'b0, sel = 1'b0, wr = 1'b0;
	logic [2:0] mode = 3'h4;
	logic [8:0] pins = 9'h1ff;
	logic [3:0] fld = 4'h0, hi = 4'h0;
	wire logic pt, st, sc, en, pin, oe, fx, rf, tt, up, dbg, bs, rsv;
	wire logic [8:0] addr, set;
	wire logic [3:0] wfo;
	wire logic [scm_pkg::QTR_W+scm_pkg::ND_W-1:0] tk;
	int mismatches = 0, num_checks = 0;
	always #12.5 system_clock_i = ~system_clock_i;
	scm_strap_model PM (.mode_i(mode), .pins_i(pins), .pll_test_o(pt), .selftest_o(st), .scan_o(sc), .addr_o(addr));
	scm_top DUT (.system_clock_i(system_clock_i), .sys_rst_i(sys_rst_i), .system_reset_n_i(rst_n), .pll_test_strap_i(pt),
		.selftest_strap_i(st), .scan_strap_i(sc), .addr_strap_i(addr), .bus_clock_pin_disable_i(dis),
		.timer_fixed_sel_i(sel), .pll_ctrl_wr_i(wr), .pll_multiplier_write_field_i(fld), .bus_clk_en_o(en),
		.bus_ticks_o(tk), .bus_clk_pin_o(pin), .bus_clk_pin_oe_o(oe), .fixed_divided_clock_o(fx),
		.refresh_tick_o(rf), .timer_tick_o(tt), .use_pll_o(up), .debug_tap_sel_o(dbg), .boundary_scan_en_o(bs),
		.mode_reserved_o(rsv), .pll_settings_o(set), .pll_multiplier_write_field_o(wfo));
	task chk(input logic ok, input string msg);
		num_checks++;
		if (ok !== 1'b1)
		begin
			mismatches++;
			$display("[FAIL] %0t %s", $time, msg);
		end
	endtask
	task boot(input logic [8:0] p, input logic by_n);
		@(posedge system_clock_i);
		pins <= p;
		if (by_n) rst_n <= 1'b0; else sys_rst_i <= 1'b1;
		repeat (3) @(posedge system_clock_i);
		#1 chk(set === 9'h10b && wfo === 4'h9 && tk === 0, "reset values");
		@(posedge system_clock_i);
		rst_n <= 1'b1;
		sys_rst_i <= 1'b0;
		wr <= 1'b1;
		fld <= 4'h5;
		@(posedge system_clock_i);
		wr <= 1'b0;
		@(posedge system_clock_i);
		hi = p[8:5] ^ 4'hb;
		#1 chk(set === (p ^ 9'h174) && wfo === 4'h9, "boot capture");
	endtask
	task t_modes;
		for (int i = 0; i < 8; i++)
		begin
			@(posedge system_clock_i);
			mode <= i[2:0];
			#1 chk({up, dbg, bs, rsv} === {i == 4 || i == 6, i == 6 || i == 7, i == 3 || i == 4,
				!(i == 3 || i == 4 || i == 6 || i == 7)}, "mode decode");
		end
	endtask
	task t_rate(input logic [2:0] m, input logic [3:0] f, input logic d, input logic s);
		int sum, cf, ct;
		sum = 0; cf = 0; ct = 0;
		@(posedge system_clock_i);
		mode <= m; dis <= d; sel <= s; wr <= 1'b1; fld <= 4'h0;
		@(posedge system_clock_i);
		fld <= f;
		@(posedge system_clock_i);
		wr <= 1'b0;
		repeat (3) @(posedge system_clock_i);
		#1 chk(set === {hi, 1'b0, f} && wfo === f, "multiplier write");
		chk(oe === !d && pin === (en & !d), "pin enable");
		repeat (20)
		begin
			@(posedge system_clock_i);
			#1 sum += tk;
			cf += fx;
			ct += tt;
		end
		chk(sum == ((m == 3'h4 || m == 3'h6) ? 5 * (f + 1) : 20), "bus rate");
		chk(cf == 4, "fixed rate");
		chk(ct == (s ? 4 : 20), "timer source");
	endtask
	task report_and_stop;
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial
	begin
		boot(9'h1ff, 1'b0);
		t_modes();
		t_rate(3'h4, 4'h3, 1'b0, 1'b1);
		t_rate(3'h6, 4'h7, 1'b1, 1'b0);
		t_rate(3'h3, 4'h7, 1'b0, 1'b0);
		boot(9'h0a5, 1'b1);
		t_rate(3'h7, 4'hb, 1'b1, 1'b1);
		report_and_stop();
	end
endmodule
`default_nettype wire
